// ---- common/gtm_pkg.sv ----
// Constants, types and register map of the general timer module
package gtm_pkg;

   // Clock and RTC second
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned RTC_PERIOD_S    = 1;
   localparam int unsigned RTC_TICK_CYCLES = RTC_PERIOD_S * CLK_HZ;

   // Block combining modes, CFG[1:0]
   typedef enum logic [1:0] {
      GTM_BLK_T32   = 2'b00,
      GTM_BLK_RTC   = 2'b01,
      GTM_BLK_SPLIT = 2'b10,
      GTM_BLK_RSVD  = 2'b11
   } gtm_blk_mode_t;

   // Half modes, CTRL[1:0]
   typedef enum logic [1:0] {
      GTM_ONESHOT  = 2'b00,
      GTM_PERIODIC = 2'b01,
      GTM_CAPTURE  = 2'b10,
      GTM_PWM      = 2'b11
   } gtm_half_mode_t;

   // CTRL field positions
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_EVT_BIT  = 2;
   localparam int unsigned CTRL_INV_BIT  = 3;
   localparam int unsigned CTRL_EN_BIT   = 4;
   localparam int unsigned CTRL_ADC_BIT  = 5;

   // Per-block word indexes; block b sits at byte b*BLK_STRIDE
   localparam logic [3:0] IDX_CFG     = 4'h0;
   localparam logic [3:0] IDX_A_CTRL  = 4'h1;
   localparam logic [3:0] IDX_B_CTRL  = 4'h2;
   localparam logic [3:0] IDX_A_LOAD  = 4'h3;
   localparam logic [3:0] IDX_B_LOAD  = 4'h4;
   localparam logic [3:0] IDX_A_PRE   = 4'h5;
   localparam logic [3:0] IDX_B_PRE   = 4'h6;
   localparam logic [3:0] IDX_A_MATCH = 4'h7;
   localparam logic [3:0] IDX_B_MATCH = 4'h8;
   localparam logic [3:0] IDX_A_VALUE = 4'h9;
   localparam logic [3:0] IDX_B_VALUE = 4'hA;
   localparam int unsigned NUM_RW_IDX = 9;
   localparam logic [7:0] BLK_STRIDE  = 8'h40;

   // Global registers
   localparam logic [7:0] OFS_INT_STAT = 8'hC0;
   localparam logic [7:0] OFS_INT_MASK = 8'hC4;

   // Reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [31:0] RST_CFG  = 32'h0000_0002;

   // AXI responses
   localparam logic [1:0] AXI_OKAY   = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;

   // Decoded settings of one half
   typedef struct packed {
      logic           enable;
      gtm_half_mode_t mode;
      logic           evt_count;
      logic           invert;
      logic           adc_en;
      logic [31:0]    load;
      logic [7:0]     pre;
      logic [31:0]    match;
   } gtm_half_cfg_t;

endpackage

// ---- hdl/gtm_block.sv ----
// One timer block: two halves, joinable into a 32-bit timer or RTC
`timescale 1ns/1ps
module gtm_block
(
   input  wire logic                           clk,
   input  wire logic                           srst,
   input  wire logic                           rtc_tick,
   input  wire gtm_pkg::gtm_blk_mode_t         blk_mode,
   input  wire gtm_pkg::gtm_half_cfg_t [1:0]   cfg,
   input  wire logic [1:0]                     ccp_in,
   output logic [1:0]                          ccp_out,
   output logic [1:0]                          ccp_oe,
   output logic [1:0]                          timeout,
   output logic [1:0]                          capture,
   output logic                                adc_trig,
   output logic [1:0][31:0]                    value
);

   logic [1:0] adc_hit;

   // Both halves share one description
   for (genvar h = 0; h < 2; h++)
   begin : g_half
      logic [31:0] cnt_reg;
      logic [7:0]  pre_reg;
      logic        run_reg;
      logic        en_d_reg;
      logic        pin_d_reg;
      logic        wide;
      logic        rtc;
      logic        active;
      logic        en;
      logic        pin_rise;
      logic        pre_hit;
      logic        tick;
      logic [31:0] top;
      logic [31:0] cnt_inc;

      assign wide     = (h == 0) && (blk_mode != gtm_pkg::GTM_BLK_SPLIT);
      assign rtc      = (h == 0) && (blk_mode == gtm_pkg::GTM_BLK_RTC);
      assign active   = (h == 0) || (blk_mode == gtm_pkg::GTM_BLK_SPLIT);
      assign en       = cfg[h].enable && active;
      assign pin_rise = ccp_in[h] && !pin_d_reg;
      // Prescaler only exists for a 16-bit half
      assign pre_hit  = wide || (pre_reg == 8'h00);
      assign tick     = rtc ? rtc_tick : (cfg[h].evt_count ? pin_rise : pre_hit);
      assign top      = wide ? cfg[h].load : {16'h0000, cfg[h].load[15:0]};
      assign cnt_inc  = cnt_reg + 32'h0000_0001;

      // Counter, prescaler and run state
      always_ff @(posedge clk)
      begin
         if (srst)
         begin
            cnt_reg    <= 32'h0000_0000;
            pre_reg    <= 8'h00;
            run_reg    <= 1'b0;
            en_d_reg   <= 1'b0;
            pin_d_reg  <= 1'b0;
            timeout[h] <= 1'b0;
         end
         else
         begin
            en_d_reg   <= en;
            pin_d_reg  <= ccp_in[h];
            timeout[h] <= 1'b0;
            if (en && !en_d_reg)
            begin
               // Rising enable loads the start value
               run_reg <= 1'b1;
               cnt_reg <= rtc ? 32'h0000_0000 : top;
               pre_reg <= cfg[h].pre;
            end
            else if (!en)
               run_reg <= 1'b0;
            else if (run_reg)
            begin
               if (!wide)
                  pre_reg <= pre_hit ? cfg[h].pre : pre_reg - 8'h01;
               if (tick)
               begin
                  if (rtc)
                  begin
                     // RTC counts up and flags each match
                     cnt_reg <= cnt_inc;
                     if (cnt_inc == cfg[h].match)
                        timeout[h] <= 1'b1;
                  end
                  else if (cnt_reg == 32'h0000_0000)
                  begin
                     timeout[h] <= 1'b1;
                     if (cfg[h].mode == gtm_pkg::GTM_ONESHOT)
                        run_reg <= 1'b0;
                     else
                        cnt_reg <= top;
                  end
                  else
                     cnt_reg <= cnt_reg - 32'h0000_0001;
               end
            end
         end
      end

      // Capture on pin edge, else mirror the count
      always_ff @(posedge clk)
      begin
         if (srst)
         begin
            value[h]   <= 32'h0000_0000;
            capture[h] <= 1'b0;
         end
         else
         begin
            capture[h] <= 1'b0;
            if (cfg[h].mode == gtm_pkg::GTM_CAPTURE && !wide)
            begin
               if (run_reg && pin_rise)
               begin
                  value[h]   <= cnt_reg;
                  capture[h] <= 1'b1;
               end
            end
            else
               value[h] <= cnt_reg;
         end
      end

      // PWM pin: high while count above match, optional inversion
      always_ff @(posedge clk)
      begin
         if (srst)
         begin
            ccp_out[h] <= 1'b0;
            ccp_oe[h]  <= 1'b0;
         end
         else
         begin
            ccp_oe[h]  <= active && !wide && cfg[h].mode == gtm_pkg::GTM_PWM;
            ccp_out[h] <= (run_reg && cnt_reg[15:0] > cfg[h].match[15:0])
                          ^ cfg[h].invert;
         end
      end

      assign adc_hit[h] = timeout[h] && cfg[h].adc_en;
   end

   // ADC start pulse, one cycle after the time-out
   always_ff @(posedge clk)
   begin
      if (srst)
         adc_trig <= 1'b0;
      else
         adc_trig <= |adc_hit;
   end

endmodule

// ---- hdl/gtm_top.sv ----
// General timer module: AXI4-Lite registers, three blocks, interrupt
`timescale 1ns/1ps
module gtm_top
#(
   parameter int unsigned NUM_BLOCKS = 3,
   parameter int unsigned RTC_DIV    = gtm_pkg::RTC_TICK_CYCLES
)
(
   input  wire logic                      clk,
   input  wire logic                      srst,
   input  wire logic [7:0]                s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [7:0]                s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   input  wire logic [2*NUM_BLOCKS-1:0]   capture_compare_pin_in,
   output logic [2*NUM_BLOCKS-1:0]        capture_compare_pin_out,
   output logic [2*NUM_BLOCKS-1:0]        capture_compare_pin_oe,
   output logic                           adc_trigger,
   output logic                           irq
);

   localparam int unsigned NSTAT = 4 * NUM_BLOCKS;

   // Three blocks at full size; block slot 3 holds the globals
   if (NUM_BLOCKS < 1 || NUM_BLOCKS > 3)
   begin : g_bad_blocks
      $error("gtm_top: NUM_BLOCKS must be 1 to 3");
   end
   if (RTC_DIV < 1)
   begin : g_bad_div
      $error("gtm_top: RTC_DIV must be at least 1");
   end

   logic [31:0]      cfg_w [NUM_BLOCKS][gtm_pkg::NUM_RW_IDX];
   logic [NSTAT-1:0] stat_reg;
   logic [NSTAT-1:0] stat_next;
   logic [NSTAT-1:0] mask_reg;
   logic [NSTAT-1:0] evt;
   logic [31:0]      rtc_cnt_reg;
   logic             rtc_tick_reg;
   logic [7:0]       awaddr_reg;
   logic [31:0]      wdata_reg;
   logic [3:0]       wstrb_reg;
   logic             aw_got_reg;
   logic             w_got_reg;
   logic             aw_hs;
   logic             w_hs;
   logic             b_hs;
   logic             ar_hs;
   logic             r_hs;
   logic             do_write;
   logic             wr_ok;
   logic             rd_ok;
   logic [31:0]      rd_word;
   logic [31:0]      mask_wr;
   logic [NUM_BLOCKS-1:0]       blk_adc;
   logic [1:0][31:0]            blk_val [NUM_BLOCKS];

   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old_w,
                                         input logic [31:0] new_w,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            res[8*i +: 8] = new_w[8*i +: 8];
      end
      return res;
   endfunction

   // Writable bits of each word; the rest read as zero
   function automatic logic [31:0] rmask(input logic [3:0] idx);
      logic [31:0] m;
      m = 32'h0000_0000;
      unique case (idx)
         gtm_pkg::IDX_CFG:     m = 32'h0000_0003;
         gtm_pkg::IDX_A_CTRL,
         gtm_pkg::IDX_B_CTRL:  m = 32'h0000_003F;
         gtm_pkg::IDX_A_LOAD,
         gtm_pkg::IDX_A_MATCH: m = 32'hFFFF_FFFF;
         gtm_pkg::IDX_B_LOAD,
         gtm_pkg::IDX_B_MATCH: m = 32'h0000_FFFF;
         gtm_pkg::IDX_A_PRE,
         gtm_pkg::IDX_B_PRE:   m = 32'h0000_00FF;
         default:              m = 32'h0000_0000;
      endcase
      return m;
   endfunction

   assign aw_hs    = s_axi_awvalid && s_axi_awready;
   assign w_hs     = s_axi_wvalid && s_axi_wready;
   assign b_hs     = s_axi_bvalid && s_axi_bready;
   assign ar_hs    = s_axi_arvalid && s_axi_arready;
   assign r_hs     = s_axi_rvalid && s_axi_rready;
   assign do_write = aw_got_reg && w_got_reg && !s_axi_bvalid;
   assign mask_wr  = merge({{(32-NSTAT){1'b0}}, mask_reg}, wdata_reg, wstrb_reg);

   // Address decode for writes: per-block words and the mask register
   assign wr_ok = (awaddr_reg == gtm_pkg::OFS_INT_MASK)
                  || ((awaddr_reg[7:6] < 2'(NUM_BLOCKS))
                      && (awaddr_reg[5:2] < 4'(gtm_pkg::NUM_RW_IDX)));

   // Write address and data, taken in either order
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         aw_got_reg    <= 1'b0;
         w_got_reg     <= 1'b0;
         awaddr_reg    <= 8'h00;
         wdata_reg     <= 32'h0000_0000;
         wstrb_reg     <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end
      else
      begin
         if (aw_hs)
         begin
            aw_got_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         else if (b_hs)
            aw_got_reg <= 1'b0;
         if (w_hs)
         begin
            w_got_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         else if (b_hs)
            w_got_reg <= 1'b0;
         // Ready again only once the previous response is taken
         s_axi_awready <= !aw_hs && (!aw_got_reg || b_hs);
         s_axi_wready  <= !w_hs && (!w_got_reg || b_hs);
      end
   end

   // Write response, two cycles after both halves arrive
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= gtm_pkg::AXI_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? gtm_pkg::AXI_OKAY : gtm_pkg::AXI_SLVERR;
      end
      else if (b_hs)
         s_axi_bvalid <= 1'b0;
   end

   // Configuration words, each block separately
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         for (int b = 0; b < NUM_BLOCKS; b++)
         begin
            for (int r = 0; r < gtm_pkg::NUM_RW_IDX; r++)
               cfg_w[b][r] <= (r == 0) ? gtm_pkg::RST_CFG : gtm_pkg::RST_WORD;
         end
      end
      else if (do_write && wr_ok && awaddr_reg[7:6] < 2'(NUM_BLOCKS))
      begin
         cfg_w[awaddr_reg[7:6]][awaddr_reg[5:2]] <=
            merge(cfg_w[awaddr_reg[7:6]][awaddr_reg[5:2]], wdata_reg, wstrb_reg)
            & rmask(awaddr_reg[5:2]);
      end
   end

   // Interrupt mask
   always_ff @(posedge clk)
   begin
      if (srst)
         mask_reg <= '0;
      else if (do_write && awaddr_reg == gtm_pkg::OFS_INT_MASK)
         mask_reg <= mask_wr[NSTAT-1:0];
   end

   // Read decode
   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_ok   = 1'b1;
      if (s_axi_araddr == gtm_pkg::OFS_INT_STAT)
         rd_word[NSTAT-1:0] = stat_reg;
      else if (s_axi_araddr == gtm_pkg::OFS_INT_MASK)
         rd_word[NSTAT-1:0] = mask_reg;
      else if (s_axi_araddr[7:6] >= 2'(NUM_BLOCKS))
         rd_ok = 1'b0;
      else if (s_axi_araddr[5:2] == gtm_pkg::IDX_A_VALUE)
         rd_word = blk_val[s_axi_araddr[7:6]][0];
      else if (s_axi_araddr[5:2] == gtm_pkg::IDX_B_VALUE)
         rd_word = blk_val[s_axi_araddr[7:6]][1];
      else if (s_axi_araddr[5:2] < 4'(gtm_pkg::NUM_RW_IDX))
         rd_word = cfg_w[s_axi_araddr[7:6]][s_axi_araddr[5:2]];
      else
         rd_ok = 1'b0;
   end

   // Read channel: one cycle from address to data
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= gtm_pkg::AXI_OKAY;
      end
      else
      begin
         s_axi_arready <= !ar_hs && (!s_axi_rvalid || r_hs);
         if (ar_hs)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? gtm_pkg::AXI_OKAY : gtm_pkg::AXI_SLVERR;
         end
         else if (r_hs)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Sticky status, cleared by reading it; a new event wins the clear
   always_comb
   begin
      stat_next = stat_reg;
      if (ar_hs && s_axi_araddr == gtm_pkg::OFS_INT_STAT)
         stat_next = '0;
      stat_next = stat_next | evt;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         stat_reg <= '0;
         irq      <= 1'b0;
      end
      else
      begin
         stat_reg <= stat_next;
         irq      <= |(stat_next & mask_reg);
      end
   end

   // Shared one-second enable for every RTC
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rtc_cnt_reg  <= 32'h0000_0000;
         rtc_tick_reg <= 1'b0;
      end
      else
      begin
         rtc_tick_reg <= (rtc_cnt_reg == 32'(RTC_DIV - 1));
         rtc_cnt_reg  <= (rtc_cnt_reg == 32'(RTC_DIV - 1)) ? 32'h0000_0000
                                                           : rtc_cnt_reg + 32'h0000_0001;
      end
   end

   // Identical blocks, each with its own configuration
   for (genvar b = 0; b < NUM_BLOCKS; b++)
   begin : g_blk
      gtm_pkg::gtm_half_cfg_t [1:0] hcfg;
      logic [1:0]                   to;
      logic [1:0]                   cap;

      for (genvar h = 0; h < 2; h++)
      begin : g_cfg
         logic [31:0] ctrl;
         assign ctrl            = cfg_w[b][1 + h];
         assign hcfg[h].enable    = ctrl[gtm_pkg::CTRL_EN_BIT];
         assign hcfg[h].mode      = gtm_pkg::gtm_half_mode_t'(ctrl[gtm_pkg::CTRL_MODE_LSB +: 2]);
         assign hcfg[h].evt_count = ctrl[gtm_pkg::CTRL_EVT_BIT];
         assign hcfg[h].invert    = ctrl[gtm_pkg::CTRL_INV_BIT];
         assign hcfg[h].adc_en    = ctrl[gtm_pkg::CTRL_ADC_BIT];
         assign hcfg[h].load      = cfg_w[b][3 + h];
         assign hcfg[h].pre       = cfg_w[b][5 + h][7:0];
         assign hcfg[h].match     = cfg_w[b][7 + h];
      end

      gtm_block u_block
      (
         .clk      (clk),
         .srst     (srst),
         .rtc_tick (rtc_tick_reg),
         .blk_mode (gtm_pkg::gtm_blk_mode_t'(cfg_w[b][0][1:0])),
         .cfg      (hcfg),
         .ccp_in   (capture_compare_pin_in[2*b +: 2]),
         .ccp_out  (capture_compare_pin_out[2*b +: 2]),
         .ccp_oe   (capture_compare_pin_oe[2*b +: 2]),
         .timeout  (to),
         .capture  (cap),
         .adc_trig (blk_adc[b]),
         .value    (blk_val[b])
      );

      // Status layout per block: A time-out, A capture, B time-out, B capture
      assign evt[4*b +: 4] = {cap[1], to[1], cap[0], to[0]};
   end

   // Any block may start a conversion
   always_ff @(posedge clk)
   begin
      if (srst)
         adc_trigger <= 1'b0;
      else
         adc_trigger <= |blk_adc;
   end

endmodule

// ---- verif/gtm_pin_model.sv ----
// Pin-side model: outside event sources and the shared capture/compare wires
`timescale 1ns/1ps
module gtm_pin_model
#(
   parameter int unsigned NUM_PINS = 6
)
(
   input  wire logic [NUM_PINS-1:0] pulse_req,
   input  wire logic                clk,
   input  wire logic [NUM_PINS-1:0] pin_out,
   input  wire logic [NUM_PINS-1:0] pin_oe,
   output logic [NUM_PINS-1:0]      pin_in
);
   logic [NUM_PINS-1:0] src_reg = '0;

   // Source answers a cycle late, as a slow sensor would
   always_ff @(posedge clk)
      src_reg <= pulse_req;

   // Wire level: the device wins while it drives, otherwise the source
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & src_reg);
endmodule

// ---- verif/gtm_top_chk.sv ----
// Handshake checks on the register bus of the timer module
`timescale 1ns/1ps
module gtm_top_chk
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        adc_trigger,
   input wire logic        irq
);
   // One clock domain, so one default clock and reset
   default clocking @(posedge clk);
   endclocking
   default disable iff (srst);

   property p_b_after;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_b_after: assert property (p_b_after) else $error("write not answered");
   property p_b_once;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_once: assert property (p_b_once) else $error("response repeated");
   // Address stays refused for two cycles after it is taken
   property p_aw_busy;
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2];
   endproperty
   a_aw_busy: assert property (p_aw_busy) else $error("address taken twice");
   property p_w_busy;
      s_axi_wvalid && s_axi_wready |=> !s_axi_wready;
   endproperty
   a_w_busy: assert property (p_w_busy) else $error("data taken twice");
   property p_r_after;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_after: assert property (p_r_after) else $error("read not answered");
   property p_r_once;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_r_once: assert property (p_r_once) else $error("read data repeated");
   property p_ar_busy;
      s_axi_arvalid && s_axi_arready |=> !s_axi_arready;
   endproperty
   a_ar_busy: assert property (p_ar_busy) else $error("read taken twice");
   // Past the last register nothing exists
   property p_r_unmapped;
      s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'hC8
      |=> s_axi_rresp == gtm_pkg::AXI_SLVERR && s_axi_rdata == 32'h0000_0000;
   endproperty
   a_r_unmapped: assert property (p_r_unmapped) else $error("unmapped read");
   c_adc: cover property (adc_trigger);
   c_irq: cover property ($rose(irq));
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind gtm_top gtm_top_chk chk_u
(
   .clk(clk), .srst(srst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .adc_trigger(adc_trigger),
   .irq(irq)
);

// ---- verif/test_general_purpose_timer_blocks.sv ----
// Self-checking bench: timer module through its registers and pins
`timescale 1ns/1ps
module test_general_purpose_timer_blocks;
   logic        clk, srst, awvalid, wvalid, bready, arvalid, rready, adc_seen;
   logic        awready, wready, bvalid, arready, rvalid, adc, irq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [1:0]  bresp, rresp, rs;
   logic [5:0]  pulse, pin_in, pin_out, pin_oe;
   int          error_cnt = 0, checks = 0, waited, hi;

   gtm_top #(.RTC_DIV(10)) dut_u
   (
      .clk(clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .capture_compare_pin_in(pin_in), .capture_compare_pin_out(pin_out),
      .capture_compare_pin_oe(pin_oe), .adc_trigger(adc), .irq(irq)
   );
   gtm_pin_model pins_u
   (
      .clk(clk), .pulse_req(pulse), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in)
   );

   task automatic close_out;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h, want %h", $time, got, exp);
      end
   endtask
   // A wait that ran out ends the run at once
   task automatic tmo(input logic ok);
      if (!ok)
      begin
         error_cnt++;
         $display("wrong value at %0t: wait ran out", $time);
         close_out();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      int   n    = 0;
      logic done = 1'b0;
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!done && n < 200)
      begin
         @(posedge clk);
         n++;
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
         begin
            done = 1'b1;
            bready <= 1'b0;
            chk({30'h0, bresp}, {30'h0, er});
         end
      end
      @(posedge clk);
      tmo(done);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      int   n    = 0;
      logic done = 1'b0;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!done && n < 200)
      begin
         @(posedge clk);
         n++;
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
         begin
            done = 1'b1;
            rready <= 1'b0;
            v = rdata;
            r = rresp;
         end
      end
      @(posedge clk);
      tmo(done);
   endtask
   // Block b register i, byte address b*0x40 + i*4
   task automatic wb(input logic [1:0] b, input logic [3:0] i, input logic [31:0] v);
      wr({b, i, 2'b00}, v, gtm_pkg::AXI_OKAY);
   endtask
   task automatic st(input logic [31:0] e);
      rd(gtm_pkg::OFS_INT_STAT, d, rs);
      chk(d, e);
   endtask
   task automatic wirq;
      waited = 0;
      while (irq !== 1'b1 && waited < 200)
      begin
         @(posedge clk);
         waited++;
      end
      tmo(irq === 1'b1);
   endtask
   // Event pin high two cycles, then low two
   task automatic pul(input logic [5:0] m);
      pulse <= m;
      repeat (2) @(posedge clk);
      pulse <= 6'h00;
      repeat (2) @(posedge clk);
   endtask
   task automatic pwm(input int exp);
      hi = 0;
      repeat (8)
      begin
         @(posedge clk);
         hi += int'(pin_out[1]);
      end
      chk(32'(hi), 32'(exp));
   endtask

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Conversion trigger is a one-cycle pulse, so latch it
   always @(posedge clk)
      adc_seen <= srst ? 1'b0 : (adc_seen || adc === 1'b1);

   initial
   begin
      {srst, awvalid, wvalid, bready, arvalid, rready, pulse} = 12'h800;
      {awaddr, araddr, wdata} = '0;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd(8'h00, d, rs);
      chk(d, gtm_pkg::RST_CFG);
      rd(8'hD0, d, rs);
      chk({30'h0, rs}, {30'h0, gtm_pkg::AXI_SLVERR});
      wr(8'h24, 32'h1, gtm_pkg::AXI_SLVERR);
      wr(gtm_pkg::OFS_INT_MASK, 32'h0000_0FFF, gtm_pkg::AXI_OKAY);
      // One-shot, prescaler 1, conversion trigger on
      wb(0, gtm_pkg::IDX_A_LOAD, 32'h3);
      wb(0, gtm_pkg::IDX_A_PRE, 32'h1);
      wb(0, gtm_pkg::IDX_A_CTRL, 32'h30);
      wirq();
      chk(32'(waited > 6), 32'h1);
      st(32'h1);
      chk(32'(adc_seen), 32'h1);
      repeat (30) @(posedge clk);
      st(32'h0);
      // Periodic reloads and fires again
      wb(1, gtm_pkg::IDX_B_LOAD, 32'h2);
      wb(1, gtm_pkg::IDX_B_CTRL, 32'h11);
      repeat (2)
      begin
         wirq();
         st(32'h40);
      end
      wb(1, gtm_pkg::IDX_B_CTRL, 32'h0);
      rd(gtm_pkg::OFS_INT_STAT, d, rs);
      // Capture on block 2 half A, pin 4
      wb(2, gtm_pkg::IDX_A_LOAD, 32'hFFFF);
      wb(2, gtm_pkg::IDX_A_CTRL, 32'h12);
      pul(6'h10);
      wirq();
      st(32'h200);
      wb(2, gtm_pkg::IDX_A_CTRL, 32'h0);
      // Edge counting: three edges from a load of 2
      wb(2, gtm_pkg::IDX_B_LOAD, 32'h2);
      wb(2, gtm_pkg::IDX_B_CTRL, 32'h14);
      repeat (2) pul(6'h20);
      st(32'h0);
      pul(6'h20);
      wirq();
      st(32'h400);
      // Waveform, match 0 in a period of 4, inverted then plain
      wb(0, gtm_pkg::IDX_B_LOAD, 32'h3);
      wb(0, gtm_pkg::IDX_B_CTRL, 32'h1B);
      chk(32'(pin_oe[1]), 32'h1);
      pwm(2);
      wb(0, gtm_pkg::IDX_B_CTRL, 32'h13);
      pwm(6);
      wb(0, gtm_pkg::IDX_B_CTRL, 32'h0);
      chk(32'(pin_oe[1]), 32'h0);
      rd(gtm_pkg::OFS_INT_STAT, d, rs);
      // Clock mode on block 1 with the interrupt masked, then unmasked
      wr(gtm_pkg::OFS_INT_MASK, 32'h0, gtm_pkg::AXI_OKAY);
      wb(1, gtm_pkg::IDX_CFG, 32'h1);
      wb(1, gtm_pkg::IDX_A_MATCH, 32'h2);
      wb(1, gtm_pkg::IDX_A_CTRL, 32'h10);
      repeat (40) @(posedge clk);
      chk(32'(irq), 32'h0);
      wr(gtm_pkg::OFS_INT_MASK, 32'h10, gtm_pkg::AXI_OKAY);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h1);
      st(32'h10);
      // Joined halves keep the upper half of the load
      wb(2, gtm_pkg::IDX_CFG, 32'h0);
      wb(2, gtm_pkg::IDX_A_LOAD, 32'h0001_0040);
      wb(2, gtm_pkg::IDX_A_CTRL, 32'h11);
      rd(8'hA4, d, rs);
      chk({16'h0, d[31:16]}, 32'h1);
      close_out();
   end
endmodule
